/* verilog/uwt_pkg.sv */
// uart package constants, register layout and the baud counter module
`timescale 1ns/1ps
package uwt_pkg;
  // byte offsets on the register bus
  localparam logic [4:0] UWT_OFS_CTRL   = 5'h00;
  localparam logic [4:0] UWT_OFS_DATA   = 5'h04;
  localparam logic [4:0] UWT_OFS_TCTRL  = 5'h08;
  localparam logic [4:0] UWT_OFS_RELOAD = 5'h0c;
  localparam logic [4:0] UWT_OFS_TLOW   = 5'h10;
  localparam logic [4:0] UWT_OFS_STAT   = 5'h14;
  // reset values
  localparam logic [7:0] UWT_CTRL_RST   = 8'h00;
  localparam logic [4:0] UWT_TCTRL_RST  = 5'h00;
  localparam logic [7:0] UWT_RELOAD_RST = 8'h00;
  // prescaler: one counter of 48 states gives /4, /12 and /48
  localparam logic [5:0] UWT_PRE_LAST   = 6'h2f;
  localparam logic [2:0] UWT_OSC_LAST   = 3'h7;
  localparam logic [2:0] UWT_DATA_LAST  = 3'h7;
  // timer clock source codes
  localparam logic [2:0] UWT_SEL_SYS    = 3'h0;
  localparam logic [2:0] UWT_SEL_DIV4   = 3'h1;
  localparam logic [2:0] UWT_SEL_DIV12  = 3'h2;
  localparam logic [2:0] UWT_SEL_DIV48  = 3'h3;
  localparam logic [2:0] UWT_SEL_OSC8   = 3'h4;
  localparam logic [2:0] UWT_SEL_EXT    = 3'h5;

  // serial_control_reg, bit 7 down to bit 0
  typedef struct packed {
    logic frame_mode_select;
    logic unused;
    logic multiproc_enable;
    logic rx_enable_bit;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } uwt_ctrl_t;

  // timer control, bit 4 down to bit 0
  typedef struct packed {
    logic       irq_enable;
    logic [2:0] clk_sel;
    logic       run;
  } uwt_tctrl_t;
endpackage

// auto-reload 8-bit counter with divide-by-two baud tick
module uwt_baud_ctr
  import uwt_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             tick_i,
  input  wire logic [CNT_W-1:0] reload_i,
  input  wire logic             force_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] load_val_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  baud_o
);
  if (CNT_W != 8) begin : g_chk
    $error("uwt_baud_ctr: counter must be 8 bits");
  end

  logic [CNT_W-1:0] next_count;
  logic             half;
  logic             next_half;
  logic             next_baud;

  // overflow reloads; every second overflow is a baud tick
  always_comb begin
    next_count = count_o;
    next_half  = half;
    next_baud  = 1'b0;
    if (force_i) begin
      next_count = reload_i;
      next_half  = 1'b0;     // first overflow after a start lands mid-bit
    end else if (load_i) begin
      next_count = load_val_i;
    end else if (run_i && tick_i) begin
      if (&count_o) begin
        next_count = reload_i;
        next_half  = ~half;
        next_baud  = ~half;
      end else begin
        next_count = count_o + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= '0;
      half    <= 1'b0;
      baud_o  <= 1'b0;
    end else begin
      count_o <= next_count;
      half    <= next_half;
      baud_o  <= next_baud;
    end
  end
endmodule // uwt_baud_ctr

/* verilog/uwt_uart.sv */
// uart with timer baud generator, avalon-mm register slave
`timescale 1ns/1ps
module uwt_uart
  import uwt_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        serial_rx_pin_i,
  output logic             serial_tx_pin_o,
  input  wire logic        ext_osc_i,
  input  wire logic        baud_timer_ext_input_i,
  output logic             irq_o
);
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_NINTH, TX_STOP} uwt_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} uwt_rx_t;

  uwt_ctrl_t  ctrl, next_ctrl;
  uwt_tctrl_t tctrl, next_tctrl;
  logic [7:0] baud_reload_value, next_reload;
  logic [7:0] serial_data_buffer, next_rbuf;
  logic [31:0] next_rdata;
  logic       next_wait, next_irq;
  logic       acc_wr;
  logic [5:0] pre_cnt, next_pre;
  logic [2:0] osc_cnt, next_osc_cnt;
  logic       rx_s1, rx_s2, rx_d;
  logic       osc_s1, osc_s2, osc_d;
  logic       ext_s1, ext_s2, ext_d;
  logic       timer_tick;
  logic [7:0] baud_timer_low_count, rx_count;
  logic       tx_baud, rx_baud, rx_force, tlow_load;
  uwt_tx_t    tx_state, next_tx_state;
  logic [7:0] tx_sh, next_tx_sh;
  logic [2:0] tx_cnt, next_tx_cnt;
  logic       tx_b9, next_tx_b9, next_tx_pin, tx_set, tx_go;
  uwt_rx_t    rx_state, next_rx_state;
  logic [7:0] rx_sh, next_rx_sh;
  logic [2:0] rx_cnt, next_rx_cnt;
  logic       rx_b9, next_rx_b9, rx_load, rx_chk;

  // register read mux; unmapped offsets read as zero
  function automatic logic [31:0] rd_mux(input logic [4:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == UWT_OFS_CTRL) begin
      d[7:0] = ctrl;
    end else if (a == UWT_OFS_DATA) begin
      d[7:0] = serial_data_buffer;
    end else if (a == UWT_OFS_TCTRL) begin
      d[4:0] = tctrl;
    end else if (a == UWT_OFS_RELOAD) begin
      d[7:0] = baud_reload_value;
    end else if (a == UWT_OFS_TLOW) begin
      d[7:0] = baud_timer_low_count;
    end else if (a == UWT_OFS_STAT) begin
      d[1:0] = {rx_state != RX_IDLE, tx_state != TX_IDLE};
    end
    return d;
  endfunction

  // prescaler tick for the selected source: counter at 47 covers all three rates
  function automatic logic pre_tick(input logic [5:0] c, input logic [2:0] sel);
    logic t;
    t = 1'b0;
    if (sel == UWT_SEL_DIV4) begin
      t = (c[1:0] == 2'h3);
    end else if (sel == UWT_SEL_DIV12) begin
      t = (c == 6'h0b) || (c == 6'h17) || (c == 6'h23) || (c == UWT_PRE_LAST);
    end else if (sel == UWT_SEL_DIV48) begin
      t = (c == UWT_PRE_LAST);
    end
    return t;
  endfunction

  // bus: one wait cycle, then a single cycle with waitrequest low
  assign acc_wr = avs_write_i && !avs_waitrequest_o;
  always_comb begin
    next_wait  = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    next_rdata = avs_readdata_o;
    if (avs_read_i && avs_waitrequest_o) begin
      next_rdata = rd_mux(avs_address_i);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= next_wait;
      avs_readdata_o    <= next_rdata;
    end
  end

  // software registers; hardware sets are applied last so a set beats a clear
  assign tlow_load = acc_wr && (avs_address_i == UWT_OFS_TLOW);
  assign tx_go     = acc_wr && (avs_address_i == UWT_OFS_DATA) && (tx_state == TX_IDLE);
  always_comb begin
    next_ctrl   = ctrl;
    next_tctrl  = tctrl;
    next_reload = baud_reload_value;
    next_rbuf   = serial_data_buffer; // only the receiver writes it
    if (acc_wr && avs_address_i == UWT_OFS_CTRL) begin
      next_ctrl        = avs_writedata_i[7:0];
      next_ctrl.unused = 1'b0;
    end else if (acc_wr && avs_address_i == UWT_OFS_TCTRL) begin
      next_tctrl = avs_writedata_i[4:0];
    end else if (acc_wr && avs_address_i == UWT_OFS_RELOAD) begin
      next_reload = avs_writedata_i[7:0];
    end
    if (tx_set) begin
      next_ctrl.tx_done_flag = 1'b1;
    end
    if (rx_load) begin
      next_ctrl.rx_done_flag = 1'b1;
      next_ctrl.rx_ninth_bit = rx_chk;
      next_rbuf              = rx_sh;
    end
    next_irq = tctrl.irq_enable && (ctrl.tx_done_flag || ctrl.rx_done_flag);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl               <= UWT_CTRL_RST;
      tctrl              <= UWT_TCTRL_RST;
      baud_reload_value  <= UWT_RELOAD_RST;
      serial_data_buffer <= 8'h00;
      irq_o              <= 1'b0;
    end else begin
      ctrl               <= next_ctrl;
      tctrl              <= next_tctrl;
      baud_reload_value  <= next_reload;
      serial_data_buffer <= next_rbuf;
      irq_o              <= next_irq;
    end
  end

  // pin synchronisers and timer clock prescaler
  always_comb begin
    next_pre     = (pre_cnt == UWT_PRE_LAST) ? 6'h00 : pre_cnt + 6'h01;
    next_osc_cnt = (osc_s2 && !osc_d) ? osc_cnt + 3'h1 : osc_cnt;
    timer_tick   = pre_tick(pre_cnt, tctrl.clk_sel);
    if (tctrl.clk_sel == UWT_SEL_SYS) begin
      timer_tick = 1'b1;
    end else if (tctrl.clk_sel == UWT_SEL_OSC8) begin
      timer_tick = osc_s2 && !osc_d && (osc_cnt == UWT_OSC_LAST);
    end else if (tctrl.clk_sel == UWT_SEL_EXT) begin
      timer_tick = ext_s2 && !ext_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt <= 6'h00;
      osc_cnt <= 3'h0;
      {rx_s1, rx_s2, rx_d}    <= 3'b111;
      {osc_s1, osc_s2, osc_d} <= 3'b000;
      {ext_s1, ext_s2, ext_d} <= 3'b000;
    end else begin
      pre_cnt <= next_pre;
      osc_cnt <= next_osc_cnt;
      {rx_s1, rx_s2, rx_d}    <= {serial_rx_pin_i, rx_s1, rx_s2};
      {osc_s1, osc_s2, osc_d} <= {ext_osc_i, osc_s1, osc_s2};
      {ext_s1, ext_s2, ext_d} <= {baud_timer_ext_input_i, ext_s1, ext_s2};
    end
  end

  // visible tx counter and hidden rx duplicate share run and reload
  uwt_baud_ctr #(.CNT_W(8)) u_tx_ctr (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .run_i      (tctrl.run),
    .tick_i     (timer_tick),
    .reload_i   (baud_reload_value),
    .force_i    (1'b0),
    .load_i     (tlow_load),
    .load_val_i (avs_writedata_i[7:0]),
    .count_o    (baud_timer_low_count),
    .baud_o     (tx_baud)
  );

  uwt_baud_ctr #(.CNT_W(8)) u_rx_ctr (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .run_i      (tctrl.run),
    .tick_i     (timer_tick),
    .reload_i   (baud_reload_value),
    .force_i    (rx_force),
    .load_i     (1'b0),
    .load_val_i (8'h00),
    .count_o    (rx_count),
    .baud_o     (rx_baud)
  );

  // transmitter; a data write while busy is dropped
  always_comb begin
    next_tx_state = tx_state;
    next_tx_sh    = tx_sh;
    next_tx_cnt   = tx_cnt;
    next_tx_b9    = tx_b9;
    next_tx_pin   = serial_tx_pin_o;
    tx_set        = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        if (tx_go) begin
          next_tx_sh    = avs_writedata_i[7:0];
          next_tx_b9    = ctrl.tx_ninth_bit;
          next_tx_state = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (tx_baud) begin
          next_tx_pin   = 1'b0;
          next_tx_state = TX_START;
        end
      end
      TX_START: begin
        if (tx_baud) begin
          next_tx_pin   = tx_sh[0];
          next_tx_cnt   = 3'h0;
          next_tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_baud) begin
          if (tx_cnt == UWT_DATA_LAST) begin
            if (ctrl.frame_mode_select) begin
              next_tx_pin   = tx_b9;
              next_tx_state = TX_NINTH;
            end else begin
              next_tx_pin   = 1'b1;
              tx_set        = 1'b1;
              next_tx_state = TX_STOP;
            end
          end else begin
            next_tx_sh  = {1'b0, tx_sh[7:1]};
            next_tx_pin = tx_sh[1];
            next_tx_cnt = tx_cnt + 3'h1;
          end
        end
      end
      TX_NINTH: begin
        if (tx_baud) begin
          next_tx_pin   = 1'b1;
          tx_set        = 1'b1;
          next_tx_state = TX_STOP;
        end
      end
      default: begin
        if (tx_baud) begin
          next_tx_state = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state        <= TX_IDLE;
      tx_sh           <= 8'h00;
      tx_cnt          <= 3'h0;
      tx_b9           <= 1'b0;
      serial_tx_pin_o <= 1'b1;
    end else begin
      tx_state        <= next_tx_state;
      tx_sh           <= next_tx_sh;
      tx_cnt          <= next_tx_cnt;
      tx_b9           <= next_tx_b9;
      serial_tx_pin_o <= next_tx_pin;
    end
  end

  // receiver; shifter is separate from the read buffer so a frame may overlap
  assign rx_force = (rx_state == RX_IDLE) && ctrl.rx_enable_bit && rx_d && !rx_s2;
  assign rx_chk   = ctrl.frame_mode_select ? rx_b9 : rx_s2;
  always_comb begin
    next_rx_state = rx_state;
    next_rx_sh    = rx_sh;
    next_rx_cnt   = rx_cnt;
    next_rx_b9    = rx_b9;
    rx_load       = 1'b0;
    case (rx_state)
      RX_IDLE: begin
        if (rx_force) begin
          next_rx_state = RX_START;
        end
      end
      RX_START: begin
        if (rx_baud) begin
          next_rx_cnt   = 3'h0;
          next_rx_state = rx_s2 ? RX_IDLE : RX_DATA; // false start is dropped
        end
      end
      RX_DATA: begin
        if (rx_baud) begin
          next_rx_sh  = {rx_s2, rx_sh[7:1]};
          next_rx_cnt = rx_cnt + 3'h1;
          if (rx_cnt == UWT_DATA_LAST) begin
            next_rx_state = ctrl.frame_mode_select ? RX_NINTH : RX_STOP;
          end
        end
      end
      RX_NINTH: begin
        if (rx_baud) begin
          next_rx_b9    = rx_s2;
          next_rx_state = RX_STOP;
        end
      end
      default: begin
        if (rx_baud) begin
          rx_load       = !ctrl.rx_done_flag && (!ctrl.multiproc_enable || rx_chk);
          next_rx_state = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state <= RX_IDLE;
      rx_sh    <= 8'h00;
      rx_cnt   <= 3'h0;
      rx_b9    <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_sh    <= next_rx_sh;
      rx_cnt   <= next_rx_cnt;
      rx_b9    <= next_rx_b9;
    end
  end

  // checks
  sequence s_data_write;
    acc_wr && (avs_address_i == UWT_OFS_DATA) && (tx_state == TX_IDLE);
  endsequence
  sequence s_stop_edge;
    (tx_state != TX_STOP) ##1 (tx_state == TX_STOP);
  endsequence

  a_tx_write_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_data_write |=> (tx_state == TX_WAIT) && (tx_sh == $past(avs_writedata_i[7:0])))
    else $error("data write did not arm the transmitter");
  a_rx_buf_safe: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rx_load |=> $stable(serial_data_buffer))
    else $error("receive buffer changed without a receive load");
  a_read_data: assert property (@(posedge core_clk_i) disable iff (rst_i)
    avs_read_i && avs_waitrequest_o && avs_address_i == UWT_OFS_DATA
      |=> !avs_waitrequest_o && avs_readdata_o == {24'h000000, $past(serial_data_buffer)})
    else $error("data read did not return the receive buffer");
  a_irq_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tctrl.irq_enable && (ctrl.tx_done_flag || ctrl.rx_done_flag) |=> irq_o)
    else $error("interrupt missing while a done flag is set");
  a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctrl.tx_done_flag && !(acc_wr && avs_address_i == UWT_OFS_CTRL) |=> ctrl.tx_done_flag)
    else $error("tx done flag cleared by hardware");
  a_rx_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rx_force |=> rx_count == $past(baud_reload_value) ##1 rx_state == RX_START)
    else $error("start edge did not reload the rx counter");
  a_start_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tx_state == TX_START |-> !serial_tx_pin_o)
    else $error("start bit not low");
  a_ti_at_stop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_stop_edge |-> ctrl.tx_done_flag && serial_tx_pin_o)
    else $error("tx done flag not set at start of stop bit");
  a_rx_overrun: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rx_load |-> !ctrl.rx_done_flag ##1 ctrl.rx_done_flag && serial_data_buffer == $past(rx_sh))
    else $error("receive load broke its conditions");
  a_idle_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tx_state == TX_IDLE |-> serial_tx_pin_o)
    else $error("tx line not high while idle");
endmodule // uwt_uart

/* sim/uwt_serial_partner.sv */
// remote serial transceiver model facing the uart pins
`timescale 1ns/1ps
module uwt_serial_partner (
  input  wire logic core_clk_i,
  input  wire logic tx_line_i,
  output logic      rx_line_o
);
  int bit_cycles = 16;

  // the line idles high, as a pulled-up wire would
  initial rx_line_o = 1'b1;

  // one bit held for a whole bit time, changed just after an edge
  task automatic put_bit(input logic b);
    rx_line_o <= b;
    repeat (bit_cycles) @(posedge core_clk_i);
  endtask

  // start, eight bits lsb first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic nine, input logic ninth);
    @(posedge core_clk_i);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      put_bit(d[i]);
    end
    if (nine) begin
      put_bit(ninth);
    end
    put_bit(1'b1);
  endtask

  // waits for a start edge, then samples each bit near its middle
  task automatic recv(input logic nine, output logic [7:0] d, output logic ninth,
                      output logic stop);
    int n;
    n = 0;
    d = 8'h00;
    ninth = 1'b0;
    while (tx_line_i !== 1'b0 && n < 40000) begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (bit_cycles / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cycles) @(posedge core_clk_i);
      d[i] = tx_line_i;
    end
    if (nine) begin
      repeat (bit_cycles) @(posedge core_clk_i);
      ninth = tx_line_i;
    end
    repeat (bit_cycles) @(posedge core_clk_i);
    stop = tx_line_i;
    // let the stop bit run out, else the next data write would be dropped as busy
    repeat (bit_cycles / 2 + 2) @(posedge core_clk_i);
  endtask
endmodule // uwt_serial_partner

/* sim/testbench.sv */
// self-checking testbench for the uart with timer baud generator
`timescale 1ns/1ps
module testbench;
  import uwt_pkg::*;
  logic        core_clk;
  logic        rst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rx_line;
  logic        tx_line;
  logic        irq;
  logic        ext_osc;
  logic        ext_in;
  int          err_count;
  int          comparisons;
  logic [31:0] rd_val;
  logic [7:0]  got_byte;
  logic        got_ninth;
  logic        got_stop;
  int          div_tab [6] = '{1, 4, 12, 48, 16, 2};

  uwt_uart uut (
    .core_clk_i             (core_clk),
    .rst_i                  (rst),
    .avs_address_i          (address),
    .avs_read_i             (read),
    .avs_write_i            (write),
    .avs_writedata_i        (writedata),
    .avs_readdata_o         (readdata),
    .avs_waitrequest_o      (waitrequest),
    .serial_rx_pin_i        (rx_line),
    .serial_tx_pin_o        (tx_line),
    .ext_osc_i              (ext_osc),
    .baud_timer_ext_input_i (ext_in),
    .irq_o                  (irq)
  );

  uwt_serial_partner far_end (
    .core_clk_i (core_clk),
    .tx_line_i  (tx_line),
    .rx_line_o  (rx_line)
  );

  // 10 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // both external timer pins toggle every core cycle: a rising edge every two cycles,
  // slow enough for the two-flop synchronisers to catch each one
  initial begin
    ext_osc = 1'b0;
    ext_in  = 1'b0;
    forever begin
      @(posedge core_clk);
      ext_osc <= ~ext_osc;
      ext_in  <= ~ext_in;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer: held until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= ~is_wr;
    write <= is_wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    check({31'h0, waitrequest}, 32'h0);
    rd_val = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd_val, exp);
  endtask

  task automatic finish_test;
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog sized well above the slowest frames at /48
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    $display("Error at %0t: timeout %h expected %h", $time, 1'b1, 1'b0);
    finish_test();
  end

  initial begin
    rst = 1'b1;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge core_clk);
    check({31'h0, tx_line}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rst <= 1'b0;
    @(posedge core_clk);
    rd_chk(UWT_OFS_CTRL, {24'h0, UWT_CTRL_RST});
    rd_chk(5'h18, 32'h0);
    rd_chk(UWT_OFS_STAT, 32'h0);
    // timer is stopped after reset, so a loaded low count must read back unchanged
    wr(UWT_OFS_TLOW, 32'h5a);
    rd_chk(UWT_OFS_TLOW, 32'h5a);
    // reload 0xf8 gives 2*(256-0xf8) = 16 cycles a bit from the core clock
    wr(UWT_OFS_RELOAD, 32'hf8);
    rd_chk(UWT_OFS_RELOAD, 32'hf8);
    wr(UWT_OFS_TCTRL, 32'h11);
    rd_chk(UWT_OFS_TCTRL, 32'h11);
    wr(UWT_OFS_CTRL, 32'h10);
    repeat (5) @(posedge core_clk);
    far_end.send(8'h3c, 1'b0, 1'b0);
    rd_chk(UWT_OFS_DATA, 32'h3c);
    rd_chk(UWT_OFS_CTRL, 32'h15);
    check({31'h0, irq}, 32'h1);
    // second frame while the first is unread is lost, buffer keeps the first
    far_end.send(8'h55, 1'b0, 1'b0);
    rd_chk(UWT_OFS_DATA, 32'h3c);
    rd_chk(UWT_OFS_CTRL, 32'h15);
    wr(UWT_OFS_CTRL, 32'h10);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    // sweep all six timer sources; bit time scales with the divider, where
    // osc/8 of a two-cycle pin clock ticks every 16 cycles and the ext pin every 2
    for (int s = 0; s < 6; s++) begin
      far_end.bit_cycles = 16 * div_tab[s];
      wr(UWT_OFS_TCTRL, {27'h0, 1'b1, s[2:0], 1'b1});
      fork
        wr(UWT_OFS_DATA, 32'h5a ^ s);
        far_end.recv(1'b0, got_byte, got_ninth, got_stop);
      join
      check({24'h0, got_byte}, 32'h5a ^ s);
      check({31'h0, got_stop}, 32'h1);
      rd_chk(UWT_OFS_CTRL, 32'h12);
      rd_chk(UWT_OFS_DATA, 32'h3c);
      wr(UWT_OFS_CTRL, 32'h10);
    end
    // nine-bit mode, transmit with ninth set, then multiprocessor filtering
    far_end.bit_cycles = 16;
    wr(UWT_OFS_TCTRL, 32'h11);
    wr(UWT_OFS_CTRL, 32'h98);
    fork
      wr(UWT_OFS_DATA, 32'h96);
      far_end.recv(1'b1, got_byte, got_ninth, got_stop);
    join
    check({24'h0, got_byte}, 32'h96);
    check({31'h0, got_ninth}, 32'h1);
    wr(UWT_OFS_CTRL, 32'hb0);
    far_end.send(8'h11, 1'b1, 1'b0);
    rd_chk(UWT_OFS_CTRL, 32'hb0);
    far_end.send(8'h22, 1'b1, 1'b1);
    rd_chk(UWT_OFS_DATA, 32'h22);
    rd_chk(UWT_OFS_CTRL, 32'hb5);
    finish_test();
  end
endmodule // testbench
